// file: shared/sps_pkg.sv
// constants, field layout and carrier types of the sync sleep pulse scheduler
package sps_pkg;
    // clock and time base
    localparam int CLK_PERIOD_NS   = 25;
    localparam int MS_NS           = 1000000;
    localparam int TICK_CYCLES     = MS_NS / CLK_PERIOD_NS;
    localparam int PULSE_LOW_NS    = 10000;
    localparam int PULSE_CYCLES    = (PULSE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BTN_HOLD_MS     = 2000;
    localparam int STAY_AWAKE_MS   = 30000;
    localparam int DOUBLE_PRESS_MS = 1000;
    localparam int SYNC_WIN_MS     = 20;
    localparam int MIN_WAKE_MS     = 45;
    localparam int LED_SLOW_MS     = 1000;
    localparam int LED_FAST_MS     = 250;

    // register byte addresses
    localparam logic [4:0] ADDR_CTRL         = 5'h00;
    localparam logic [4:0] ADDR_SLEEP_PERIOD = 5'h04;
    localparam logic [4:0] ADDR_WAKE_TIME    = 5'h08;
    localparam logic [4:0] ADDR_COMMAND      = 5'h0c;
    localparam logic [4:0] ADDR_STATUS       = 5'h10;

    // control and command register fields
    localparam int CTRL_SM_LSB    = 0;
    localparam int CTRL_PIN_LSB   = 4;
    localparam int CTRL_PREF      = 8;
    localparam int CTRL_NONCOORD  = 9;
    localparam int CTRL_BTN_EN    = 10;
    localparam int CMD_SLEEP_NOW  = 0;
    // status register fields
    localparam int STAT_AWAKE     = 0;
    localparam int STAT_SYNCED    = 1;
    localparam int STAT_COORD     = 2;
    localparam int STAT_IN_WAKE   = 3;
    localparam int STAT_SKIP      = 4;
    localparam int STAT_WAKE_LSB  = 16;

    // encodings of mode and pin function
    localparam logic [3:0] SM_NORMAL   = 4'h0;
    localparam logic [3:0] SM_SUPPORT  = 4'h7;
    localparam logic [3:0] SM_CYCLIC   = 4'h8;
    localparam logic [3:0] PIN_FN_OFF  = 4'h0;
    localparam logic [3:0] PIN_FN_IND  = 4'h1;
    localparam logic [3:0] PIN_FN_PULSE = 4'h6;

    // reset values
    localparam logic [15:0] SP_RESET  = 16'h00c8;
    localparam logic [15:0] ST_RESET  = 16'h07d0;

    // schedule carried by sync messages, in ms
    typedef struct packed {
        logic [15:0] period;
        logic [15:0] wake;
    } sps_sched_type;

    // one register bus request
    typedef struct packed {
        logic [4:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } sps_bus_type;
endpackage

// file: design/sps_scheduler.sv
// network-synchronous sleep scheduler with pulse pin and commissioning
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
module sps_scheduler #(
    parameter int TICK_CYCLES   = sps_pkg::TICK_CYCLES,
    parameter int STAY_AWAKE_MS = sps_pkg::STAY_AWAKE_MS,
    parameter int HOLD_MS       = sps_pkg::BTN_HOLD_MS,
    parameter int MIN_WAKE_MS   = sps_pkg::MIN_WAKE_MS
) (
    input  wire logic                  clk_in,
    input  wire logic                  rst_n_in,
    input  wire sps_pkg::sps_bus_type  bus_in,
    output logic [31:0]                rdata_out,
    input  wire logic                  commissioning_button_pin_n_in,
    input  wire logic                  rx_sync_in,
    input  wire sps_pkg::sps_sched_type rx_sched_in,
    input  wire logic                  rx_sync_req_in,
    input  wire logic                  rx_sleep_now_in,
    output logic                       tx_sync_out,
    output sps_pkg::sps_sched_type     tx_sched_out,
    output logic                       tx_sync_req_out,
    output logic                       tx_sleep_now_out,
    output logic                       tx_block_out,
    output logic                       awake_out,
    output logic                       pulse_status_pin_out,
    output logic                       pulse_status_pin_oe_out,
    output logic                       assoc_led_out
);
    localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
    localparam logic [8:0]  PULSE_LEN = 9'(sps_pkg::PULSE_CYCLES);
    localparam logic [14:0] STAY_LEN  = 15'(STAY_AWAKE_MS);
    localparam logic [11:0] HOLD_LAST = 12'(HOLD_MS - 1);
    localparam logic [9:0]  DBL_LEN   = 10'(sps_pkg::DOUBLE_PRESS_MS);
    localparam logic [15:0] WAKE_MIN  = 16'(MIN_WAKE_MS);
    localparam logic [16:0] SYNC_WIN  = 17'(sps_pkg::SYNC_WIN_MS);
    localparam logic [9:0]  LED_SLOW  = 10'(sps_pkg::LED_SLOW_MS - 1);
    localparam logic [9:0]  LED_FAST  = 10'(sps_pkg::LED_FAST_MS - 1);

    // wake time never below what one pulse per cycle needs
    function automatic logic [15:0] round_wake(input logic [15:0] t);
        round_wake = (t < WAKE_MIN) ? WAKE_MIN : t;
    endfunction

    // configuration registers
    logic [3:0]  sleep_mode_select;
    logic [3:0]  pin_nine_function;
    logic        opt_pref;
    logic        opt_noncoord;
    logic        btn_en;
    logic [15:0] sleep_period;
    logic [15:0] wake_time;
    // schedule state
    logic [15:0] tick_cnt;
    logic [16:0] phase_ms;
    logic        synced;
    logic        coord;
    logic        sleep_skip;
    // button state
    logic        btn_meta;
    logic        btn_sync;
    logic        btn_prev;
    logic [11:0] held_ms;
    logic [14:0] stay_ms;
    logic [9:0]  dbl_ms;
    // pin and led state
    logic [8:0]  pulse_cnt;
    logic [9:0]  led_ms;

    // bus decode
    wire wr_ctrl  = bus_in.wr && bus_in.addr == sps_pkg::ADDR_CTRL;
    wire wr_sp    = bus_in.wr && bus_in.addr == sps_pkg::ADDR_SLEEP_PERIOD;
    wire wr_st    = bus_in.wr && bus_in.addr == sps_pkg::ADDR_WAKE_TIME;
    wire wr_cmd   = bus_in.wr && bus_in.addr == sps_pkg::ADDR_COMMAND;
    wire cmd_sleep_now = wr_cmd && bus_in.wdata[sps_pkg::CMD_SLEEP_NOW];

    // mode decode
    wire mode_support = sleep_mode_select == sps_pkg::SM_SUPPORT;
    wire mode_cyclic  = sleep_mode_select == sps_pkg::SM_CYCLIC;
    wire sync_mode    = mode_support || mode_cyclic;
    wire pin_is_ind   = pin_nine_function == sps_pkg::PIN_FN_IND;
    wire pin_is_pulse = pin_nine_function == sps_pkg::PIN_FN_PULSE;

    // cycle timing: phase 0 is the start of wake
    wire [15:0] wake_eff  = round_wake(wake_time);
    wire        sp_zero   = sleep_period == 16'h0000;
    wire [16:0] cycle_len = sp_zero ? {1'b0, wake_eff}
                                    : {1'b0, wake_eff} + {1'b0, sleep_period};
    wire        tick      = tick_cnt == TICK_LAST;
    wire        in_wake   = sp_zero || phase_ms < {1'b0, wake_eff};
    wire        wake_start = tick && phase_ms >= cycle_len - 17'h00001;
    wire        rx_take   = rx_sync_in && sync_mode && !coord;
    wire        wake_ev   = wake_start || rx_take;

    // awake decision; stay-awake from the button overrides the schedule
    wire awake_now = !sync_mode || mode_support
                     || stay_ms != 15'h0000 || sp_zero
                     || (in_wake && !sleep_skip);

    // sleep-now: only meaningful in the wake part of a sync cycle
    wire skip_set  = sync_mode && in_wake && !wake_ev
                     && (cmd_sleep_now || rx_sleep_now_in);
    wire next_skip = skip_set || (sleep_skip && !wake_ev);

    // phase keeps running through a sleep-now, so a node that missed it stays aligned
    wire [16:0] next_phase = wake_ev ? 17'h00000
                           : tick ? phase_ms + 17'h00001 : phase_ms;
    wire [15:0] next_tick  = (tick || rx_take) ? 16'h0000 : tick_cnt + 16'h0001;

    // button press and hold
    wire press      = btn_sync && !btn_prev && btn_en;
    wire long_hold  = tick && btn_sync && btn_en && held_ms == HOLD_LAST;
    wire eligible   = sync_mode && !opt_noncoord;
    wire nominate   = press && dbl_ms != 10'h0000 && eligible;
    wire wake_press = press && synced && !awake_now && mode_cyclic;
    wire stay_load  = wake_press || (long_hold && mode_cyclic);
    wire [14:0] next_stay = stay_load ? STAY_LEN
                          : (tick && stay_ms != 15'h0000) ? stay_ms - 15'h0001 : stay_ms;
    wire [9:0]  next_dbl  = (press && dbl_ms == 10'h0000) ? DBL_LEN
                          : nominate ? 10'h0000
                          : (tick && dbl_ms != 10'h0000) ? dbl_ms - 10'h001 : dbl_ms;
    wire [11:0] next_held = !btn_sync ? 12'h000
                          : (tick && held_ms != HOLD_LAST) ? held_ms + 12'h001 : held_ms;

    // coordinator and sync state; leaving sync mode drops both
    wire next_coord  = sync_mode && !opt_noncoord
                       && (opt_pref || coord || nominate);
    wire next_synced = sync_mode && (synced || rx_take || next_coord);

    // outgoing messages
    wire send_sync = sync_mode && ((coord && wake_start)
                     || (rx_sync_req_in && awake_now && synced));
    wire send_req  = sync_mode && !synced && !coord && wake_ev;

    // pulse counter: low phase of fixed width at each wake start once synced
    wire pulse_mode = pin_is_pulse && sync_mode && synced;
    wire pulse_load = pulse_mode && wake_ev;
    wire [8:0] next_pulse = pulse_load ? PULSE_LEN
                          : (pulse_cnt != 9'h000) ? pulse_cnt - 9'h001 : 9'h000;
    // one function value selects either indicator or pulse, never both
    wire next_pin = pin_is_ind ? awake_now : next_pulse == 9'h000;
    wire next_oe  = pin_is_ind || pin_is_pulse;

    // led: slow as coordinator, fast when awake and synced
    wire       led_on    = coord || (sync_mode && synced && awake_now);
    wire [9:0] led_last  = coord ? LED_SLOW : LED_FAST;
    wire       led_flip  = tick && led_ms >= led_last;
    wire [9:0] next_led  = (!led_on || led_flip) ? 10'h000
                         : tick ? led_ms + 10'h001 : led_ms;

    // read mux; unmapped addresses read zero
    logic [31:0] ctrl_word;
    logic [31:0] stat_word;
    logic [31:0] rd_word;
    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[sps_pkg::CTRL_SM_LSB +: 4]  = sleep_mode_select;
        ctrl_word[sps_pkg::CTRL_PIN_LSB +: 4] = pin_nine_function;
        ctrl_word[sps_pkg::CTRL_PREF]         = opt_pref;
        ctrl_word[sps_pkg::CTRL_NONCOORD]     = opt_noncoord;
        ctrl_word[sps_pkg::CTRL_BTN_EN]       = btn_en;
        stat_word = 32'h0000_0000;
        stat_word[sps_pkg::STAT_AWAKE]        = awake_now;
        stat_word[sps_pkg::STAT_SYNCED]       = synced;
        stat_word[sps_pkg::STAT_COORD]        = coord;
        stat_word[sps_pkg::STAT_IN_WAKE]      = in_wake;
        stat_word[sps_pkg::STAT_SKIP]         = sleep_skip;
        stat_word[sps_pkg::STAT_WAKE_LSB +: 16] = wake_eff;
        unique case (bus_in.addr)
            sps_pkg::ADDR_CTRL:         rd_word = ctrl_word;
            sps_pkg::ADDR_SLEEP_PERIOD: rd_word = {16'h0000, sleep_period};
            sps_pkg::ADDR_WAKE_TIME:    rd_word = {16'h0000, wake_time};
            sps_pkg::ADDR_STATUS:       rd_word = stat_word;
            default:                    rd_word = 32'h0000_0000;
        endcase
    end

    // configuration; written by software only, a sync never changes it
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sleep_mode_select <= sps_pkg::SM_NORMAL;
            pin_nine_function <= sps_pkg::PIN_FN_OFF;
            opt_pref          <= 1'b0;
            opt_noncoord      <= 1'b0;
            btn_en            <= 1'b1;
        end else if (wr_ctrl) begin
            sleep_mode_select <= bus_in.wdata[sps_pkg::CTRL_SM_LSB +: 4];
            pin_nine_function <= bus_in.wdata[sps_pkg::CTRL_PIN_LSB +: 4];
            opt_pref          <= bus_in.wdata[sps_pkg::CTRL_PREF];
            opt_noncoord      <= bus_in.wdata[sps_pkg::CTRL_NONCOORD];
            btn_en            <= bus_in.wdata[sps_pkg::CTRL_BTN_EN];
        end
    end

    // schedule values, written by software or adopted from a sync
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sleep_period <= sps_pkg::SP_RESET;
            wake_time    <= sps_pkg::ST_RESET;
        end else begin
            if (wr_sp)
                sleep_period <= bus_in.wdata[15:0];
            else if (rx_take)
                sleep_period <= rx_sched_in.period;
            if (wr_st)
                wake_time <= bus_in.wdata[15:0];
            else if (rx_take)
                wake_time <= rx_sched_in.wake;
        end
    end

    // schedule state
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            tick_cnt   <= 16'h0000;
            phase_ms   <= 17'h00000;
            synced     <= 1'b0;
            coord      <= 1'b0;
            sleep_skip <= 1'b0;
        end else begin
            tick_cnt   <= next_tick;
            phase_ms   <= next_phase;
            synced     <= next_synced;
            coord      <= next_coord;
            sleep_skip <= next_skip;
        end
    end

    // button synchroniser and timers; of the synchroniser stages only btn_sync and btn_prev are read by logic
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            btn_meta <= 1'b0;
            btn_sync <= 1'b0;
            btn_prev <= 1'b0;
            held_ms  <= 12'h000;
            stay_ms  <= 15'h0000;
            dbl_ms   <= 10'h000;
        end else begin
            btn_meta <= !commissioning_button_pin_n_in;
            btn_sync <= btn_meta;
            btn_prev <= btn_sync;
            held_ms  <= next_held;
            stay_ms  <= next_stay;
            dbl_ms   <= next_dbl;
        end
    end

    // registered outputs; edge comes straight from the shared wake start
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            tx_sync_out             <= 1'b0;
            tx_sched_out            <= '0;
            tx_sync_req_out         <= 1'b0;
            tx_sleep_now_out        <= 1'b0;
            awake_out               <= 1'b1;
            pulse_cnt               <= 9'h000;
            pulse_status_pin_out    <= 1'b1;
            pulse_status_pin_oe_out <= 1'b0;
            led_ms                  <= 10'h000;
            assoc_led_out           <= 1'b0;
            rdata_out               <= 32'h0000_0000;
        end else begin
            tx_sync_out             <= send_sync;
            tx_sched_out            <= '{period: sleep_period, wake: wake_eff};
            tx_sync_req_out         <= send_req;
            tx_sleep_now_out        <= cmd_sleep_now && skip_set;
            awake_out               <= awake_now;
            pulse_cnt               <= next_pulse;
            pulse_status_pin_out    <= next_pin;
            pulse_status_pin_oe_out <= next_oe;
            led_ms                  <= next_led;
            assoc_led_out           <= led_on && (led_flip ? !assoc_led_out : assoc_led_out);
            rdata_out               <= bus_in.rd ? rd_word : 32'h0000_0000;
        end
    end

    // tx blocked outside the sync window only while this node sleeps
    assign tx_block_out = sync_mode && (!awake_now || phase_ms < SYNC_WIN);

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    logic [9:0] low_run;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in)
            low_run <= 10'h000;
        else
            low_run <= pulse_status_pin_out ? 10'h000 : low_run + 10'h001;
    end

    sequence s_pulse_low;
        (!pulse_status_pin_out && pulse_status_pin_oe_out)[*8];
    endsequence
    sequence s_sleep_cmd;
        cmd_sleep_now && sync_mode && in_wake && !wake_ev;
    endsequence

    chk_sleep_now_tx: assert property (s_sleep_cmd |=> tx_sleep_now_out && !awake_now
        || stay_ms != 15'h0000 || mode_support)
        else $error("sleep-now not broadcast or node stayed awake");
    chk_skip_holds: assert property ((sleep_skip && mode_cyclic && stay_ms == 15'h0000
        && !sp_zero) |-> !awake_out || $past(awake_now))
        else $error("node woke during skipped cycle");
    chk_phase_kept: assert property ((rx_sleep_now_in && !tick && !rx_take)
        |=> $stable(phase_ms))
        else $error("sleep-now disturbed cycle phase");
    chk_pulse_start: assert property ((pulse_load && !pin_is_ind) |=> s_pulse_low)
        else $error("pulse low phase missing");
    chk_pulse_width: assert property ((pin_is_pulse && $rose(pulse_status_pin_out)
        && $past(pin_is_pulse)) |-> low_run == 10'(sps_pkg::PULSE_CYCLES))
        else $error("pulse low width wrong");
    chk_pin_shared: assert property (pin_is_ind |=> pulse_status_pin_out == $past(awake_now)
        && pulse_status_pin_oe_out)
        else $error("sleep indicator not on pin");
    chk_no_sync_off: assert property (!sync_mode |=> !tx_sync_out && !tx_sync_req_out)
        else $error("sync traffic outside sync modes");
    chk_sp_zero_awake: assert property (sp_zero |-> awake_now)
        else $error("sleep period zero but asleep");
    chk_wake_min: assert property (wake_eff >= WAKE_MIN && cycle_len > 17'h00000)
        else $error("wake time below minimum");
    chk_tx_window: assert property ((tx_block_out && awake_now) |-> phase_ms < SYNC_WIN)
        else $error("tx blocked outside sync window");
    chk_req_answer: assert property ((rx_sync_req_in && sync_mode && synced && awake_now)
        |=> tx_sync_out)
        else $error("sync request not answered");
    chk_support_awake: assert property (mode_support |=> awake_out)
        else $error("sleep-support node slept");
endmodule // sps_scheduler

// file: tb/sps_peer_model.sv
// peer node model that answers sync requests with its own schedule
`timescale 1ns/1ps
module sps_peer_model #(
    parameter int          DELAY  = 3,
    parameter logic [15:0] PERIOD = 16'h0032,
    parameter logic [15:0] WAKE   = 16'h0002
) (
    input  wire logic              clk_in,
    input  wire logic              tx_sync_req_in,
    output logic                   rx_sync_out,
    output sps_pkg::sps_sched_type rx_sched_out
);
    int wait_cnt = -1;
    initial begin
        rx_sync_out = 1'b0;
        rx_sched_out = '0;
    end
    // reply after a short delay; schedule is junk outside the strobe
    always @(posedge clk_in) begin
        rx_sync_out <= 1'b0;
        rx_sched_out <= ~rx_sched_out;
        if (tx_sync_req_in) begin
            wait_cnt <= DELAY;
        end else if (wait_cnt > 0) begin
            wait_cnt <= wait_cnt - 1;
        end else if (wait_cnt == 0) begin
            wait_cnt <= -1;
            rx_sync_out <= 1'b1;
            rx_sched_out <= '{period: PERIOD, wake: WAKE};
        end
    end
endmodule // sps_peer_model

// file: tb/tb_top.sv
// self-checking bench for the sync sleep pulse scheduler
`timescale 1ns/1ps
module tb_top;
    localparam int TK = 10;
    localparam int PER = 50;
    logic                   clk_in = 1'b0;
    logic                   rst_n_in = 1'b0;
    sps_pkg::sps_bus_type   bus = '0;
    logic                   btn_n = 1'b1;
    logic                   rx_req = 1'b0;
    logic                   rx_sleep = 1'b0;
    logic                   rx_sync, tx_sync, tx_req, tx_sleep, tx_block, awake, pin, pin_oe;
    logic                   led;
    logic [31:0]            rdata, d;
    sps_pkg::sps_sched_type rx_sched, tx_sched;
    int                     bad_count = 0;
    int                     checks = 0;
    int                     i, n;

    // 40 MHz clock
    always #12.5 clk_in = ~clk_in;

    sps_scheduler #(.TICK_CYCLES(TK), .STAY_AWAKE_MS(50), .HOLD_MS(5), .MIN_WAKE_MS(4))
    sps_scheduler_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus_in(bus), .rdata_out(rdata),
        .commissioning_button_pin_n_in(btn_n), .rx_sync_in(rx_sync), .rx_sched_in(rx_sched),
        .rx_sync_req_in(rx_req), .rx_sleep_now_in(rx_sleep), .tx_sync_out(tx_sync),
        .tx_sched_out(tx_sched), .tx_sync_req_out(tx_req), .tx_sleep_now_out(tx_sleep),
        .tx_block_out(tx_block), .awake_out(awake), .pulse_status_pin_out(pin),
        .pulse_status_pin_oe_out(pin_oe), .assoc_led_out(led));

    // peer answers at any time, so the joining node always meets a wake window
    sps_peer_model #(.PERIOD(16'h0032)) sps_peer_model_i (.clk_in(clk_in),
        .tx_sync_req_in(tx_req), .rx_sync_out(rx_sync), .rx_sched_out(rx_sched));

    task test_done;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // a bound that ran out ends the run
    task limit(input int lim);
        if (i >= lim) begin
            $display("Error wait on %0d cycles ran out", lim);
            bad_count++;
            test_done;
        end
    endtask
    task step;
        @(posedge clk_in);
        #1;
    endtask
    task wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge clk_in) bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in) bus <= '0;
        #1;
    endtask
    task rd(input logic [4:0] a, output logic [31:0] v);
        @(posedge clk_in) bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in) bus <= '0;
        #1 v = rdata;
    endtask
    task send_req;
        @(posedge clk_in) rx_req <= 1'b1;
        @(posedge clk_in) rx_req <= 1'b0;
        #1;
    endtask
    task press;
        @(posedge clk_in) btn_n <= 1'b0;
        repeat (6) @(posedge clk_in);
        btn_n <= 1'b1;
        repeat (6) step;
    endtask

    // reset state and register defaults, unmapped read
    task t_reset;
        rd(sps_pkg::ADDR_CTRL, d);
        check("ctrl", d, 32'h00000400);
        rd(sps_pkg::ADDR_SLEEP_PERIOD, d);
        check("period", d, 32'h000000c8);
        rd(5'h14, d);
        check("unmapped", d, 32'h0);
        check("awake", awake, 1'b1);
        check("block", tx_block, 1'b0);
        send_req;
        check("no answer", tx_sync, 1'b0);
    endtask
    // unsynced node asks, adopts the peer schedule, short wake rounded up
    task t_join;
        wr(sps_pkg::ADDR_SLEEP_PERIOD, 32'h64);
        wr(sps_pkg::ADDR_WAKE_TIME, 32'h2);
        wr(sps_pkg::ADDR_CTRL, 32'h468);
        for (i = 0; i < 2500 && tx_req !== 1'b1; i++) step;
        limit(2500);
        check("req", tx_req, 1'b1);
        repeat (10) step;
        rd(sps_pkg::ADDR_STATUS, d);
        check("synced", d[1], 1'b1);
        check("wake eff", d[31:16], 32'h4);
        check("pin oe", pin_oe, 1'b1);
    endtask
    // pulse low phase has the fixed width
    task t_pulse;
        for (i = 0; i < 1500 && pin !== 1'b1; i++) step;
        limit(1500);
        for (i = 0; i < 1500 && pin !== 1'b0; i++) step;
        limit(1500);
        for (n = 0; n < 1000 && pin === 1'b0; n++) step;
        check("low width", n, sps_pkg::PULSE_CYCLES);
    endtask
    // answer a request, then sleep-now for the rest of the cycle
    task t_sleep;
        for (i = 0; i < 1500 && awake !== 1'b0; i++) step;
        for (i = 0; i < 1500 && awake !== 1'b1; i++) step;
        limit(1500);
        send_req;
        check("answer", tx_sync, 1'b1);
        check("sched", tx_sched, {16'h0032, 16'h0004});
        wr(sps_pkg::ADDR_COMMAND, 32'h1);
        check("bcast", tx_sleep, 1'b1);
        check("blocked", tx_block, 1'b1);
        // awake_out is registered from the skip flag, so it drops one cycle later
        step;
        check("asleep", awake, 1'b0);
        for (n = 0; n < 2000 && awake !== 1'b1; n++) step;
        check("long sleep", n >= PER * TK, 1'b1);
        check("resumed", n <= (PER + 4) * TK, 1'b1);
    endtask
    // double press nominates the coordinator
    task t_button;
        press;
        press;
        rd(sps_pkg::ADDR_STATUS, d);
        check("coord", d[2], 1'b1);
        // coordinator led toggles only after a full slow period
        for (i = 0; i < 10100 && led !== 1'b1; i++) step;
        limit(10100);
        check("led slow", i >= 990 * TK, 1'b1);
    endtask

    // main sequence
    initial begin
        repeat (8) @(posedge clk_in);
        rst_n_in <= 1'b1;
        step;
        t_reset;
        t_join;
        t_pulse;
        t_sleep;
        t_button;
        test_done;
    end
endmodule // tb_top
